// ===== logic/ascr_conv_if.sv
// Link between the register logic and the approximation sequencer
`timescale 1ns/1ps
`default_nettype none

interface ascr_conv_if;
  import ascr_pkg::*;

  logic run;
  logic restart;
  logic done;
  ascr_result_t result;

  modport ctrl (output run, output restart, input done, input result);
  modport seq (input run, input restart, output done, output result);
endinterface

`default_nettype wire

// ===== logic/ascr_params.svh
// Register map, field positions, reset values and timing of the converter control block
`ifndef ASCR_PARAMS_SVH
`define ASCR_PARAMS_SVH

// Printed register indices; byte address is four times the index
`define ASCR_IDX_CSR 8'h70
`define ASCR_IDX_RES_UPPER 8'h71
`define ASCR_IDX_RES_LOWER 8'h72
`define ASCR_IDX_EVT_STATUS 8'h73
`define ASCR_IDX_EVT_MASK 8'h74

// Control/status fields
`define ASCR_CSR_DONE_BIT 7
`define ASCR_CSR_SPEED_BIT 6
`define ASCR_CSR_ON_BIT 5
`define ASCR_CSR_RSVD_BIT 4
`define ASCR_CSR_CH_MSB 3
`define ASCR_CSR_CH_LSB 0

// Event status and mask fields
`define ASCR_EVT_DONE_BIT 0
`define ASCR_EVT_SETTLED_BIT 1
`define ASCR_EVT_WIDTH 2

// Reset values
`define ASCR_CSR_RESET 8'h00
`define ASCR_RES_UPPER_RESET 8'h00
`define ASCR_RES_LOWER_RESET 8'h00
`define ASCR_EVT_RESET 2'h0

// Converter clock dividers
`define ASCR_DIV_SLOW 3'h4
`define ASCR_DIV_FAST 3'h2

// Timing
`define ASCR_CLK_PERIOD_NS 20
`define ASCR_WAKE_SETTLE_NS 20000
`define ASCR_SAMPLE_TICKS 4

`endif

// ===== logic/ascr_pkg.sv
// Types shared by the converter control modules
package ascr_pkg;

  typedef logic [9:0] ascr_result_t;
  typedef logic [3:0] ascr_channel_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_SAMPLE = 3'b010,
    SEQ_CONVERT = 3'b100
  } ascr_seq_state_e;

endpackage

// ===== logic/ascr_sar_seq.sv
// Successive-approximation sequencer: sample phase then ten bit trials
`timescale 1ns/1ps
`default_nettype none
`include "ascr_params.svh"

module ascr_sar_seq
  import ascr_pkg::*;
#(
  parameter int SAMPLE_TICKS = `ASCR_SAMPLE_TICKS
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_tick,
  input wire logic i_compare_high,
  ascr_conv_if.seq conv,
  output logic o_sample_hold,
  output ascr_result_t o_trial_code
);

  ascr_seq_state_e state_reg;
  logic [7:0] sample_cnt_reg;
  ascr_result_t acc_reg;
  ascr_result_t bit_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_srst || !conv.run) begin
      conv.result <= 10'h000;
      state_reg <= SEQ_IDLE;
      sample_cnt_reg <= 8'h00;
      acc_reg <= 10'h000;
      bit_reg <= 10'h200;
      conv.done <= 1'b0;
    end else if (conv.restart) begin
      state_reg <= SEQ_SAMPLE;
      sample_cnt_reg <= 8'h00;
      acc_reg <= 10'h000;
      bit_reg <= 10'h200;
      conv.done <= 1'b0;
    end else begin
      conv.done <= 1'b0;
      unique case (state_reg)
        SEQ_IDLE: begin
          state_reg <= SEQ_SAMPLE;
        end
        SEQ_SAMPLE: begin
          if (i_tick) begin
            if (sample_cnt_reg == 8'(SAMPLE_TICKS - 1)) begin
              state_reg <= SEQ_CONVERT;
            end else begin
              sample_cnt_reg <= sample_cnt_reg + 8'h01;
            end
          end
        end
        SEQ_CONVERT: begin
          if (i_tick) begin
            // Keep the trial bit while the input is at or above it; saturates at both ends
            if (i_compare_high) begin // R16
              acc_reg <= acc_reg | bit_reg;
            end
            bit_reg <= bit_reg >> 1;
            if (bit_reg == 10'h001) begin
              conv.done <= 1'b1; // R17
              conv.result <= i_compare_high ? (acc_reg | bit_reg) : acc_reg;
              state_reg <= SEQ_SAMPLE; // R13
              sample_cnt_reg <= 8'h00;
              bit_reg <= 10'h200;
              // Next conversion starts from an empty accumulator
              acc_reg <= 10'h000;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_sample_hold <= 1'b0;
      o_trial_code <= 10'h000;
    end else begin
      o_sample_hold <= (state_reg == SEQ_SAMPLE) && conv.run && !conv.restart;
      o_trial_code <= acc_reg | bit_reg;
    end
  end

endmodule

`default_nettype wire

// ===== logic/ascr_tick_gen.sv
// Converter clock enable: one tick every two or four core clocks
`timescale 1ns/1ps
`default_nettype none
`include "ascr_params.svh"

module ascr_tick_gen
  import ascr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_enable,
  input wire logic i_fast,
  output logic o_tick
);

  logic [2:0] count_reg;
  logic [2:0] limit;

  assign limit = i_fast ? `ASCR_DIV_FAST : `ASCR_DIV_SLOW;

  always_ff @(posedge i_core_clk) begin
    if (i_srst || !i_enable) begin
      count_reg <= 3'h0;
      o_tick <= 1'b0;
    end else if (count_reg >= limit - 3'h1) begin
      count_reg <= 3'h0;
      o_tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 3'h1;
      o_tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== logic/ascr_top.sv
// Converter control block: APB registers, converter clock and result handling
//
// How it works
// R1: Done flag sets on completion; cleared by upper-byte read or any control write.
// R2: Control register read/write except done flag, which ignores writes.
// R3: Speed bit clear divides core clock by four, set divides by two.
// R4: Clearing converter_on stops conversion; setting it starts converting.
// R5: Software writes zero to reserved bit four; it reads back zero.
// R6: Four channel_select bits pick input zero to fifteen in plain binary.
// R7: Upper result register shows result bits nine down to two.
// R8: Lower result register holds bits one and zero, upper six read zero.
// R9: Reset clears control and both result registers to zero.
// R10: Wait mode leaves the converter running unchanged.
// R11: Halt disables the converter; software waits settle time after wake.
// R12: Registers sit at indices 70h, 71h and 72h.
// R13: While enabled, conversions of the selected channel repeat back to back.
// R14: Channel change aborts conversion, clears done flag, restarts on new channel.
// R15: Results update on every completion, unlatched; read lower then upper.
// R16: Input beyond references saturates to all ones or zeros, no overflow flag.
// R17: Each conversion takes fixed converter ticks, then results and flag load together.
// R18: The converter itself raises no request; software polls the done flag. Here an unmasked done event in the event status register also drives o_irq.
`timescale 1ns/1ps
`default_nettype none
`include "ascr_params.svh"

module ascr_top
  import ascr_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int SAMPLE_TICKS = `ASCR_SAMPLE_TICKS,
  parameter int WAKE_SETTLE_CYCLES =
    (`ASCR_WAKE_SETTLE_NS + `ASCR_CLK_PERIOD_NS - 1) / `ASCR_CLK_PERIOD_NS
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_WIDTH-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_halt_mode,
  input wire logic i_compare_high,
  output ascr_channel_t o_channel_select,
  output logic o_converter_enable,
  output logic o_sample_hold,
  output ascr_result_t o_trial_code,
  output logic o_irq
);

  localparam int SETTLE_W = $clog2(WAKE_SETTLE_CYCLES + 1);

  // Register index of a byte address
  function automatic logic [ADDR_WIDTH-3:0] word_index(input logic [ADDR_WIDTH-1:0] addr);
    word_index = addr[ADDR_WIDTH-1:2];
  endfunction

  function automatic logic hits(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] idx);
    hits = (word_index(addr) == (ADDR_WIDTH-2)'(idx)) && (addr[1:0] == 2'b00);
  endfunction

  ascr_conv_if conv ();

  logic speed_reg;
  logic on_reg;
  ascr_channel_t channel_reg;
  logic done_reg;
  logic [7:0] res_upper_reg;
  logic [1:0] res_lower_reg;
  logic [`ASCR_EVT_WIDTH-1:0] evt_status_reg;
  logic [`ASCR_EVT_WIDTH-1:0] evt_mask_reg;
  logic restart_reg;
  logic halt_d_reg;
  logic settling_reg;
  logic [SETTLE_W-1:0] settle_cnt_reg;
  logic tick;

  logic setup;
  logic access_done;
  logic wr_csr;
  logic rd_upper;
  logic wr_evt_status;
  logic wr_evt_mask;
  logic mapped;
  logic run;
  logic settle_event;
  logic [`ASCR_EVT_WIDTH-1:0] evt_set;
  logic conv_done_ok;

  assign setup = i_psel && !i_penable;
  assign access_done = i_psel && i_penable && o_pready;
  assign mapped = hits(i_paddr, `ASCR_IDX_CSR) || hits(i_paddr, `ASCR_IDX_RES_UPPER) ||
    hits(i_paddr, `ASCR_IDX_RES_LOWER) || hits(i_paddr, `ASCR_IDX_EVT_STATUS) ||
    hits(i_paddr, `ASCR_IDX_EVT_MASK);
  assign wr_csr = access_done && i_pwrite && hits(i_paddr, `ASCR_IDX_CSR); // R12
  assign rd_upper = access_done && !i_pwrite && hits(i_paddr, `ASCR_IDX_RES_UPPER);
  assign wr_evt_status = access_done && i_pwrite && hits(i_paddr, `ASCR_IDX_EVT_STATUS);
  assign wr_evt_mask = access_done && i_pwrite && hits(i_paddr, `ASCR_IDX_EVT_MASK);

  // Halt stops the converter; wait mode has no input here and so no effect
  assign run = on_reg && !i_halt_mode; // R4 R10 R11
  assign settle_event = settling_reg && (settle_cnt_reg == SETTLE_W'(1));
  // Completions of an aborted or stopped conversion are dropped
  assign conv_done_ok = conv.done && run && !restart_reg; // R4 R14

  // APB handshake: one-cycle access phase, ready from a flop
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
    end
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup && !i_pwrite) begin
      o_prdata <= 32'h0000_0000;
      if (hits(i_paddr, `ASCR_IDX_CSR)) begin
        // Reserved bit reads zero
        o_prdata[7:0] <= {done_reg, speed_reg, on_reg, 1'b0, channel_reg}; // R2 R5
      end else if (hits(i_paddr, `ASCR_IDX_RES_UPPER)) begin
        o_prdata[7:0] <= res_upper_reg; // R7
      end else if (hits(i_paddr, `ASCR_IDX_RES_LOWER)) begin
        o_prdata[7:0] <= {6'h00, res_lower_reg}; // R8
      end else if (hits(i_paddr, `ASCR_IDX_EVT_STATUS)) begin
        o_prdata[`ASCR_EVT_WIDTH-1:0] <= evt_status_reg;
      end else if (hits(i_paddr, `ASCR_IDX_EVT_MASK)) begin
        o_prdata[`ASCR_EVT_WIDTH-1:0] <= evt_mask_reg;
      end
    end else if (!i_psel) begin
      o_prdata <= 32'h0000_0000;
    end
  end

  // Control fields; the done bit position is not writable
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      speed_reg <= 1'((`ASCR_CSR_RESET >> `ASCR_CSR_SPEED_BIT) & 8'h01); // R9
      on_reg <= 1'b0;
      channel_reg <= 4'h0;
    end else if (wr_csr) begin
      speed_reg <= i_pwdata[`ASCR_CSR_SPEED_BIT]; // R2 R3
      on_reg <= i_pwdata[`ASCR_CSR_ON_BIT]; // R4
      channel_reg <= i_pwdata[`ASCR_CSR_CH_MSB:`ASCR_CSR_CH_LSB]; // R6
    end
  end

  // Abort and restart on a channel change while running
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_csr && run && i_pwdata[`ASCR_CSR_ON_BIT] &&
        (i_pwdata[`ASCR_CSR_CH_MSB:`ASCR_CSR_CH_LSB] != channel_reg); // R14
    end
  end

  // Done flag: a completion in the clearing cycle wins
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      done_reg <= 1'b0; // R9
    end else if (conv_done_ok) begin
      done_reg <= 1'b1; // R1 R17
    end else if (rd_upper || wr_csr) begin
      done_reg <= 1'b0; // R1 R14
    end
  end

  // Results follow every completion with no hold-off
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      res_upper_reg <= `ASCR_RES_UPPER_RESET; // R9
      res_lower_reg <= 2'(`ASCR_RES_LOWER_RESET & 8'h03);
    end else if (conv_done_ok) begin
      res_upper_reg <= conv.result[9:2]; // R7 R15
      res_lower_reg <= conv.result[1:0]; // R8 R15
    end
  end

  // Settle count after leaving halt
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      halt_d_reg <= 1'b0;
      settling_reg <= 1'b0;
      settle_cnt_reg <= '0;
    end else begin
      halt_d_reg <= i_halt_mode;
      if (i_halt_mode) begin
        settling_reg <= 1'b0;
        settle_cnt_reg <= '0;
      end else if (halt_d_reg) begin
        settling_reg <= 1'b1; // R11
        settle_cnt_reg <= SETTLE_W'(WAKE_SETTLE_CYCLES);
      end else if (settling_reg) begin
        settle_cnt_reg <= settle_cnt_reg - SETTLE_W'(1);
        if (settle_event) begin
          settling_reg <= 1'b0;
        end
      end
    end
  end

  // Sticky events, write one to clear, set wins
  assign evt_set = {settle_event, conv_done_ok};

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      evt_status_reg <= `ASCR_EVT_RESET;
    end else begin
      evt_status_reg <= evt_set |
        (evt_status_reg & ~(wr_evt_status ? i_pwdata[`ASCR_EVT_WIDTH-1:0] : `ASCR_EVT_RESET));
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      evt_mask_reg <= `ASCR_EVT_RESET;
    end else if (wr_evt_mask) begin
      evt_mask_reg <= i_pwdata[`ASCR_EVT_WIDTH-1:0];
    end
  end

  // Only the software-unmasked wrapper events reach the line
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(evt_status_reg & evt_mask_reg); // R18
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_channel_select <= 4'h0;
      o_converter_enable <= 1'b0;
    end else begin
      o_channel_select <= channel_reg; // R6
      o_converter_enable <= run; // R4 R11
    end
  end

  assign conv.run = run;
  assign conv.restart = restart_reg;

  ascr_tick_gen u_tick (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_enable(run),
    .i_fast(speed_reg), // R3
    .o_tick(tick)
  );

  ascr_sar_seq #(
    .SAMPLE_TICKS(SAMPLE_TICKS)
  ) u_seq (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_tick(tick),
    .i_compare_high(i_compare_high),
    .conv(conv.seq),
    .o_sample_hold(o_sample_hold),
    .o_trial_code(o_trial_code)
  );

endmodule

`default_nettype wire

// ===== verif/ascr_analog_model.sv
// Input multiplexer and comparator model for the approximation core
`timescale 1ns/1ps
`default_nettype none
module ascr_analog_model
  import ascr_pkg::*;
(
  input wire logic i_core_clk,
  input wire ascr_channel_t i_channel_select,
  input wire logic i_converter_enable,
  input wire ascr_result_t i_trial_code,
  output logic o_compare_high
);
  logic flip = 1'b0;
  logic hit;
  // Disabled comparator output is meaningless, so it wanders
  always_ff @(posedge i_core_clk) begin
    flip <= ~flip;
  end
  always_comb begin
    case (i_channel_select)
      4'hF: hit = 1'b1;
      4'h0: hit = 1'b0;
      default: hit = {i_channel_select, 6'h15} >= i_trial_code;
    endcase
  end
  assign o_compare_high = i_converter_enable ? hit : flip;
endmodule
`default_nettype wire

// ===== verif/ascr_top_sva.sv
// Port checker of the converter control block
`timescale 1ns/1ps
`default_nettype none
module ascr_top_sva
  import ascr_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_WIDTH-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_halt_mode,
  input wire logic i_compare_high,
  input wire ascr_channel_t o_channel_select,
  input wire logic o_converter_enable,
  input wire logic o_sample_hold,
  input wire ascr_result_t o_trial_code,
  input wire logic o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  AST_READY_NEXT: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  AST_RDATA_BYTE: assert property (o_prdata[31:8] == 24'h000000)
    else $error("read data above byte");
  AST_RDATA_IDLE: assert property ($past(!i_psel) && !i_psel |-> o_prdata == 32'h00000000)
    else $error("read data outside read");
  AST_HALT_OFF: assert property (i_halt_mode ##1 i_halt_mode |-> !o_converter_enable)
    else $error("enabled in halt");
  AST_OFF_NO_SAMPLE: assert property (!o_converter_enable [*2] |-> !o_sample_hold)
    else $error("sampling while off");
  AST_CH_BY_WRITE: assert property ($changed(o_channel_select)
    |-> $past(i_psel && i_penable && i_pwrite && o_pready, 2))
    else $error("channel moved without write");
  AST_RESET_CLEAR: assert property ($fell(i_srst)
    |-> !o_irq && !o_converter_enable && o_trial_code == 10'h000)
    else $error("outputs not cleared by reset");
  cover property (o_pslverr);
  cover property (o_irq);
  cover property (i_halt_mode ##1 !i_halt_mode);
endmodule
bind ascr_top ascr_top_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_ascr_top_sva (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_halt_mode(i_halt_mode),
  .i_compare_high(i_compare_high), .o_channel_select(o_channel_select),
  .o_converter_enable(o_converter_enable), .o_sample_hold(o_sample_hold),
  .o_trial_code(o_trial_code), .o_irq(o_irq));
`default_nettype wire

// ===== verif/ascr_top_test.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "ascr_params.svh"
module ascr_top_test;
  import ascr_pkg::*;
  localparam logic [11:0] A_CSR = {`ASCR_IDX_CSR, 2'b00};
  localparam logic [11:0] A_UP = {`ASCR_IDX_RES_UPPER, 2'b00};
  localparam logic [11:0] A_LO = {`ASCR_IDX_RES_LOWER, 2'b00};
  localparam logic [11:0] A_ST = {`ASCR_IDX_EVT_STATUS, 2'b00};
  localparam logic [11:0] A_MK = {`ASCR_IDX_EVT_MASK, 2'b00};
  localparam int TICKS = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic halt = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, cmp, en, sh, irq, err;
  logic [31:0] rd;
  ascr_channel_t ch;
  ascr_result_t code;
  int n_mismatch = 0;
  int compares = 0;
  int sh_cnt = 0;
  int sh_len = 0;
  initial forever #10 clk = ~clk;
  ascr_top #(.SAMPLE_TICKS(TICKS), .WAKE_SETTLE_CYCLES(8)) u_ascr_top (
    .i_core_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_halt_mode(halt), .i_compare_high(cmp), .o_channel_select(ch),
    .o_converter_enable(en), .o_sample_hold(sh), .o_trial_code(code), .o_irq(irq));
  ascr_analog_model u_ascr_analog_model (.i_core_clk(clk), .i_channel_select(ch),
    .i_converter_enable(en), .i_trial_code(code), .o_compare_high(cmp));
  // Length of the last finished sample phase
  always @(posedge clk) begin
    if (sh === 1'b1) sh_cnt <= sh_cnt + 1;
    else if (sh_cnt != 0) begin
      sh_len <= sh_cnt;
      sh_cnt <= 0;
    end
  end
  task automatic end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %b", $time, msg, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk_bit(pready, 1'b1, "ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_val(rd, exp, "read");
  endtask
  task automatic wait_done;
    int i = 0;
    do begin
      apb(1'b0, A_CSR, 32'h0);
      i++;
    end while (rd[7] !== 1'b1 && i < 100);
    chk_bit(rd[7], 1'b1, "done");
  endtask
  task automatic t_reset;
    rdc(A_CSR, 32'h0);
    rdc(A_UP, 32'h0);
    rdc(A_LO, 32'h0);
    chk_bit(irq, 1'b0, "irq");
  endtask
  task automatic t_refuse;
    apb(1'b0, 12'h1D4, 32'h0);
    chk_bit(err, 1'b1, "err");
    chk_val(rd, 32'h0, "bad read");
    apb(1'b1, A_UP, 32'hFF);
    chk_bit(err, 1'b0, "err");
    rdc(A_UP, 32'h0);
    apb(1'b1, A_CSR, 32'h9F);
    rdc(A_CSR, 32'h0F);
    chk_val({28'h0, ch}, 32'hF, "channel");
  endtask
  task automatic t_chan;
    ascr_result_t e;
    for (int c = 0; c < 16; c++) begin
      e = (c == 15) ? 10'h3FF : (c == 0) ? 10'h000 : {c[3:0], 6'h15};
      apb(1'b1, A_CSR, 32'h60 | c);
      repeat (2) @(posedge clk);
      chk_val({28'h0, ch}, c, "channel");
      wait_done();
      rdc(A_LO, {30'h0, e[1:0]});
      rdc(A_UP, {24'h0, e[9:2]});
      apb(1'b0, A_CSR, 32'h0);
      chk_bit(rd[7], 1'b0, "done clear");
    end
  endtask
  task automatic t_speed;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, A_CSR, s ? 32'h65 : 32'h25);
      wait_done();
      // Two more completions so the measured sample phase is a full one
      repeat (2) begin
        apb(1'b1, A_CSR, s ? 32'h65 : 32'h25);
        apb(1'b0, A_CSR, 32'h0);
        chk_bit(rd[7], 1'b0, "done clear");
        wait_done();
      end
      chk_val(sh_len, TICKS * (s ? `ASCR_DIV_FAST : `ASCR_DIV_SLOW), "sample");
    end
  endtask
  task automatic t_halt;
    apb(1'b1, A_MK, 32'h0);
    apb(1'b1, A_CSR, 32'h63);
    wait_done();
    chk_bit(irq, 1'b0, "masked");
    apb(1'b1, A_MK, 32'h3);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b1, "irq");
    halt <= 1'b1;
    repeat (4) @(posedge clk);
    chk_bit(en, 1'b0, "halt");
    apb(1'b0, A_CSR, 32'h0);
    chk_val({25'h0, rd[6:0]}, 32'h63, "kept");
    halt <= 1'b0;
    repeat (20) @(posedge clk);
    chk_bit(en, 1'b1, "woken");
    apb(1'b0, A_ST, 32'h0);
    chk_bit(rd[1], 1'b1, "settle");
    apb(1'b1, A_CSR, 32'h0);
    repeat (3) @(posedge clk);
    chk_bit(en, 1'b0, "off");
    apb(1'b1, A_ST, 32'h3);
    rdc(A_ST, 32'h0);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b0, "irq clear");
    apb(1'b1, A_CSR, 32'h0);
    repeat (80) @(posedge clk);
    rdc(A_CSR, 32'h0);
  endtask
  initial begin
    #400000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog", $time);
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_refuse();
    t_chan();
    t_speed();
    t_halt();
    end_sim();
  end
endmodule
`default_nettype wire
